// ==== core/pc_stack_pkg.sv ====
// constants for the program counter and return stack block
// assumes a 32-bit classic wishbone host and a decoder issuing commands
package pc_stack_pkg;
  localparam int PC_W = 15;
  localparam int SP_W = 5;
  localparam int DEPTH = 16;
  // decoder command codes
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_STEP = 4'h1;
  localparam logic [3:0] CMD_CALL = 4'h2;
  localparam logic [3:0] CMD_COMPUTED_CALL = 4'h3;
  localparam logic [3:0] CMD_BRW = 4'h4;
  localparam logic [3:0] CMD_BRA = 4'h5;
  localparam logic [3:0] CMD_RETURN = 4'h6;
  localparam logic [3:0] CMD_RETURN_WITH_LITERAL = 4'h7;
  localparam logic [3:0] CMD_RETURN_FROM_INTERRUPT = 4'h8;
  localparam logic [3:0] CMD_IRQ = 4'h9;
  localparam logic [3:0] CMD_WR_PCL = 4'ha;
  localparam logic [3:0] CMD_WR_LATCH = 4'hb;
  // register indices, byte address is four times the index
  localparam logic [11:0] IDX_PCL = 12'h002;
  localparam logic [11:0] IDX_LATCH = 12'h00a;
  localparam logic [11:0] IDX_CTRL = 12'h100;
  localparam logic [11:0] IDX_IRQ_ST = 12'h101;
  localparam logic [11:0] IDX_IRQ_MSK = 12'h102;
  localparam logic [11:0] IDX_ST_SH = 12'hfe4;
  localparam logic [11:0] IDX_W_SH = 12'hfe5;
  localparam logic [11:0] IDX_BSR_SH = 12'hfe6;
  localparam logic [11:0] IDX_LATCH_SH = 12'hfe7;
  localparam logic [11:0] IDX_F0L_SH = 12'hfe8;
  localparam logic [11:0] IDX_F0H_SH = 12'hfe9;
  localparam logic [11:0] IDX_F1L_SH = 12'hfea;
  localparam logic [11:0] IDX_F1H_SH = 12'hfeb;
  localparam logic [11:0] IDX_SP = 12'hfed;
  localparam logic [11:0] IDX_TOP_OF_STACK_LOW = 12'hfee;
  localparam logic [11:0] IDX_TOP_OF_STACK_HIGH = 12'hfef;
  // reset values and fixed addresses
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [4:0] SP_EMPTY = 5'h1f;
  localparam logic [4:0] SP_FULL = 5'h0f;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam logic FAULT_EN_RST = 1'b1;
  // interrupt status bit positions
  localparam int ST_OVF = 0;
  localparam int ST_UNF = 1;
endpackage : pc_stack_pkg

// ==== core/pc_stack.sv ====
// program counter sequencing, return stack and interrupt context shadows
// assumes the decoder gives at most one command per clock and pc_o holds
// the address of the instruction after the one being executed
// Operation
// - fifteen-bit counter; low byte accessible, upper seven from latch
// - any reset clears the whole counter to zero
// - writing the low byte loads counter bits 14:8 from latch
// - call: bits 10:0 from operand, bits 14:11 from latch bits 6:3
// - computed call: low byte from working reg, high part from latch
// - branch by working reg: counter plus one plus unsigned w
// - relative branch: counter plus one plus sign-extended operand
// - sixteen entry, fifteen-bit stack outside memory spaces
// - push on calls and interrupt entry, pop on three returns
// - push and pop leave the high latch unchanged, except return from interrupt reloads it from its shadow
// - fault reset off: stack wraps, overwriting oldest entries
// - overflow and underflow flags set whatever the fault option
// - low byte arithmetic never carries into the high part
// - push increments pointer then stores; pop reads then decrements
// - fault option on: overflow or underflow resets and flags
// - five-bit pointer; top-of-stack pair accesses selected entry
// - after reset the stack is empty, pointer at 0x1f
`timescale 1ns/100ps
module pc_stack (
  input wire logic clk_i, // core clock, 25 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [13:2] adr_i, // wishbone word address
  input wire logic [31:0] dat_i, // wishbone write data
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic we_i, // wishbone write enable
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic [3:0] cmd_i, // decoder command
  input wire logic [10:0] operand_i, // instruction operand
  input wire logic [7:0] data_i, // working reg or alu result
  input wire logic [2:0] status_i, // arithmetic flags to save
  input wire logic [4:0] bsr_i, // bank select to save
  input wire logic [15:0] fsr0_i, // indirect pointer 0 to save
  input wire logic [15:0] fsr1_i, // indirect pointer 1 to save
  output logic [14:0] pc_o, // program counter
  output logic [6:0] pc_high_latch_o, // high latch
  output logic ctx_restore_o, // pulse: reload context from shadows
  output logic [2:0] status_shadow_o, // saved flags
  output logic [7:0] working_reg_shadow_o, // saved working reg
  output logic [4:0] bank_select_shadow_o, // saved bank select
  output logic [15:0] fsr0_shadow_o, // saved pointer 0
  output logic [15:0] fsr1_shadow_o, // saved pointer 1
  output logic fault_reset_o, // pulse: stack fault resets device
  output logic irq_o // level: unmasked stack event pending
);
  logic [14:0] pc_q, pc_d;
  logic [6:0] latch_q, latch_d, latch_sh_q;
  logic [4:0] sp_q, sp_d;
  logic [14:0] stack_q [pc_stack_pkg::DEPTH];
  logic fault_en_q;
  logic [1:0] st_q, st_d, msk_q;
  logic ack_q, irq_q, restore_q, freset_q;
  logic [7:0] rd_q;
  logic [2:0] st_sh_q;
  logic [7:0] w_sh_q;
  logic [4:0] bsr_sh_q;
  logic [15:0] f0_sh_q, f1_sh_q;

  // bus decode; one wait state, so ack never stays high two cycles
  wire bus_req = cyc_i & stb_i & ~ack_q;
  wire bus_wr = bus_req & we_i & sel_i[0];
  wire [7:0] wd = dat_i[7:0];
  wire hit_pcl = adr_i == pc_stack_pkg::IDX_PCL;
  wire hit_latch = adr_i == pc_stack_pkg::IDX_LATCH;
  wire hit_ctrl = adr_i == pc_stack_pkg::IDX_CTRL;
  wire hit_st = adr_i == pc_stack_pkg::IDX_IRQ_ST;
  wire hit_msk = adr_i == pc_stack_pkg::IDX_IRQ_MSK;
  wire hit_sp = adr_i == pc_stack_pkg::IDX_SP;
  wire hit_top_of_stack_low = adr_i == pc_stack_pkg::IDX_TOP_OF_STACK_LOW;
  wire hit_top_of_stack_high = adr_i == pc_stack_pkg::IDX_TOP_OF_STACK_HIGH;
  wire hit_ssh = adr_i == pc_stack_pkg::IDX_ST_SH;
  wire hit_wsh = adr_i == pc_stack_pkg::IDX_W_SH;
  wire hit_bsh = adr_i == pc_stack_pkg::IDX_BSR_SH;
  wire hit_lsh = adr_i == pc_stack_pkg::IDX_LATCH_SH;
  wire hit_f0l = adr_i == pc_stack_pkg::IDX_F0L_SH;
  wire hit_f0h = adr_i == pc_stack_pkg::IDX_F0H_SH;
  wire hit_f1l = adr_i == pc_stack_pkg::IDX_F1L_SH;
  wire hit_f1h = adr_i == pc_stack_pkg::IDX_F1H_SH;

  // command decode
  wire is_push = cmd_i == pc_stack_pkg::CMD_CALL
    || cmd_i == pc_stack_pkg::CMD_COMPUTED_CALL
    || cmd_i == pc_stack_pkg::CMD_IRQ;
  wire is_pop = cmd_i == pc_stack_pkg::CMD_RETURN
    || cmd_i == pc_stack_pkg::CMD_RETURN_WITH_LITERAL
    || cmd_i == pc_stack_pkg::CMD_RETURN_FROM_INTERRUPT;
  wire is_irq = cmd_i == pc_stack_pkg::CMD_IRQ;
  wire is_return_from_interrupt = cmd_i == pc_stack_pkg::CMD_RETURN_FROM_INTERRUPT;
  wire ovf_evt = is_push && sp_q == pc_stack_pkg::SP_FULL;
  wire unf_evt = is_pop && sp_q == pc_stack_pkg::SP_EMPTY;
  wire fault = fault_en_q & (ovf_evt | unf_evt);

  // stack pointer arithmetic; low four bits index the entries so an
  // overflowing push lands on the oldest entry
  wire [4:0] sp_inc = sp_q + 5'h01;
  wire [4:0] sp_dec = sp_q - 5'h01;
  wire [14:0] tos_raw = stack_q[sp_q[3:0]];
  wire tos_zero = fault_en_q && sp_q == pc_stack_pkg::SP_EMPTY;
  wire [14:0] tos = tos_zero ? 15'h0000 : tos_raw;

  // branch targets; call return address is the current counter, already
  // advanced past the call
  wire [14:0] pc_inc = pc_q + 15'h0001;
  wire [14:0] brw_tgt = pc_inc + {7'h00, data_i};
  wire [14:0] bra_tgt = pc_inc + {{6{operand_i[8]}}, operand_i[8:0]};
  wire [14:0] call_tgt = {latch_q[6:3], operand_i};
  wire [14:0] computed_call_tgt = {latch_q, data_i};
  wire [14:0] irq_ret = is_irq ? pc_q : pc_q;

  // memory write port: push has priority over software access
  wire push_ok = is_push & ~fault;
  wire tos_wr = bus_wr & (hit_top_of_stack_low | hit_top_of_stack_high) & ~is_push & ~is_pop;
  wire mem_we = push_ok | tos_wr;
  wire [3:0] mem_idx = push_ok ? sp_inc[3:0] : sp_q[3:0];
  wire [14:0] mem_wd = push_ok ? irq_ret
    : hit_top_of_stack_low ? {tos_raw[14:8], wd} : {wd[6:0], tos_raw[7:0]};

  // next counter; fault behaves as a device reset
  always_comb begin
    pc_d = pc_q;
    if (fault) begin
      pc_d = pc_stack_pkg::PC_RST;
    end else begin
      case (cmd_i)
        pc_stack_pkg::CMD_STEP: pc_d = pc_inc;
        pc_stack_pkg::CMD_CALL: pc_d = call_tgt;
        pc_stack_pkg::CMD_COMPUTED_CALL: pc_d = computed_call_tgt;
        pc_stack_pkg::CMD_BRW: pc_d = brw_tgt;
        pc_stack_pkg::CMD_BRA: pc_d = bra_tgt;
        pc_stack_pkg::CMD_RETURN,
        pc_stack_pkg::CMD_RETURN_WITH_LITERAL,
        pc_stack_pkg::CMD_RETURN_FROM_INTERRUPT: pc_d = tos;
        pc_stack_pkg::CMD_IRQ: pc_d = pc_stack_pkg::IRQ_VECTOR;
        // the decoder adds in eight bits, so no carry reaches the top
        pc_stack_pkg::CMD_WR_PCL: pc_d = {latch_q, data_i};
        pc_stack_pkg::CMD_NONE: begin
          if (bus_wr && hit_pcl) begin
            pc_d = {latch_q, wd};
          end
        end
        default: pc_d = pc_q;
      endcase
    end
  end

  // next pointer and latch
  always_comb begin
    sp_d = sp_q;
    latch_d = latch_q;
    if (fault) begin
      sp_d = pc_stack_pkg::SP_EMPTY;
      latch_d = 7'h00;
    end else if (is_push) begin
      sp_d = sp_inc;
    end else if (is_pop) begin
      sp_d = sp_dec;
    end else if (bus_wr && hit_sp) begin
      sp_d = wd[4:0];
    end
    if (!fault && is_return_from_interrupt) begin
      latch_d = latch_sh_q;
    end else if (cmd_i == pc_stack_pkg::CMD_WR_LATCH) begin
      latch_d = data_i[6:0];
    end else if (bus_wr && hit_latch && cmd_i == pc_stack_pkg::CMD_NONE) begin
      latch_d = wd[6:0];
    end
  end

  // sticky flags: a new event wins over a write-one clear
  wire [1:0] st_clr = (bus_wr && hit_st) ? wd[1:0] : 2'b00;
  assign st_d = (st_q & ~st_clr) | {unf_evt, ovf_evt};

  // read mux
  wire [7:0] rd_d = hit_pcl ? pc_q[7:0]
    : hit_latch ? {1'b0, latch_q}
    : hit_ctrl ? {7'h00, fault_en_q}
    : hit_st ? {6'h00, st_q}
    : hit_msk ? {6'h00, msk_q}
    : hit_sp ? {3'h0, sp_q}
    : hit_top_of_stack_low ? tos[7:0]
    : hit_top_of_stack_high ? {1'b0, tos[14:8]}
    : hit_ssh ? {5'h00, st_sh_q}
    : hit_wsh ? w_sh_q
    : hit_bsh ? {3'h0, bsr_sh_q}
    : hit_lsh ? {1'b0, latch_sh_q}
    : hit_f0l ? f0_sh_q[7:0]
    : hit_f0h ? f0_sh_q[15:8]
    : hit_f1l ? f1_sh_q[7:0]
    : hit_f1h ? f1_sh_q[15:8] : 8'h00;

  // core state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= pc_stack_pkg::PC_RST;
      sp_q <= pc_stack_pkg::SP_EMPTY;
      latch_q <= 7'h00;
      st_q <= 2'b00;
    end else begin
      pc_q <= pc_d;
      sp_q <= sp_d;
      latch_q <= latch_d;
      st_q <= st_d;
    end
  end

  // stack entries hold no reset value, like the real storage
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      stack_q[mem_idx] <= mem_wd;
    end
  end

  // configuration, mask and bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_en_q <= pc_stack_pkg::FAULT_EN_RST;
      msk_q <= 2'b00;
      ack_q <= 1'b0;
      rd_q <= 8'h00;
      irq_q <= 1'b0;
      restore_q <= 1'b0;
      freset_q <= 1'b0;
    end else begin
      if (bus_wr && hit_ctrl) fault_en_q <= wd[0];
      if (bus_wr && hit_msk) msk_q <= wd[1:0];
      ack_q <= bus_req;
      rd_q <= bus_req ? rd_d : 8'h00;
      irq_q <= |(st_d & msk_q);
      restore_q <= is_return_from_interrupt & ~fault;
      freset_q <= fault;
    end
  end

  // context shadows, captured on interrupt entry; unknown after reset
  always_ff @(posedge clk_i) begin
    if (is_irq && !fault) begin
      st_sh_q <= status_i;
      w_sh_q <= data_i;
      bsr_sh_q <= bsr_i;
      latch_sh_q <= latch_q;
      f0_sh_q <= fsr0_i;
      f1_sh_q <= fsr1_i;
    end else if (bus_wr) begin
      if (hit_ssh) st_sh_q <= wd[2:0];
      if (hit_wsh) w_sh_q <= wd;
      if (hit_bsh) bsr_sh_q <= wd[4:0];
      if (hit_lsh) latch_sh_q <= wd[6:0];
      if (hit_f0l) f0_sh_q[7:0] <= wd;
      if (hit_f0h) f0_sh_q[15:8] <= wd;
      if (hit_f1l) f1_sh_q[7:0] <= wd;
      if (hit_f1h) f1_sh_q[15:8] <= wd;
    end
  end

  assign dat_o = {24'h000000, rd_q};
  assign ack_o = ack_q;
  assign pc_o = pc_q;
  assign pc_high_latch_o = latch_q;
  assign ctx_restore_o = restore_q;
  assign status_shadow_o = st_sh_q;
  assign working_reg_shadow_o = w_sh_q;
  assign bank_select_shadow_o = bsr_sh_q;
  assign fsr0_shadow_o = f0_sh_q;
  assign fsr1_shadow_o = f1_sh_q;
  assign fault_reset_o = freset_q;
  assign irq_o = irq_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property reset_clear_p;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> pc_o == 15'h0000 && sp_q == 5'h1f;
  endproperty
  reset_clear_a: assert property (reset_clear_p)
    else $error("reset did not clear counter and pointer");
  pcl_write_a: assert property (
    cmd_i == pc_stack_pkg::CMD_WR_PCL && !fault |=>
      pc_q == {$past(latch_q), $past(data_i)})
    else $error("low byte write did not load latch");
  call_target_a: assert property (
    cmd_i == pc_stack_pkg::CMD_CALL && !fault |=>
      pc_q[10:0] == $past(operand_i) && pc_q[14:11] == $past(latch_q[6:3]))
    else $error("call target wrong");
  brw_target_a: assert property (
    cmd_i == pc_stack_pkg::CMD_BRW |=>
      pc_q == 15'($past(pc_q) + 15'h0001 + {7'h00, $past(data_i)}))
    else $error("branch by w target wrong");
  bra_target_a: assert property (
    cmd_i == pc_stack_pkg::CMD_BRA |=> pc_q == 15'($past(pc_q) + 15'h0001
      + {{6{$past(operand_i[8])}}, $past(operand_i[8:0])}))
    else $error("relative branch target wrong");
  push_store_a: assert property (
    is_push && !fault |=> sp_q == 5'($past(sp_q) + 5'h01)
      && stack_q[sp_q[3:0]] == $past(pc_q))
    else $error("push did not store at incremented pointer");
  // the decoder leaves one idle cycle between commands
  call_return_a: assert property (
    cmd_i == pc_stack_pkg::CMD_CALL && !fault ##1
      cmd_i == pc_stack_pkg::CMD_NONE ##1
      cmd_i == pc_stack_pkg::CMD_RETURN |=> pc_q == $past(pc_q, 3))
    else $error("return did not restore call address");
  latch_keep_a: assert property (
    (is_push || (is_pop && !is_return_from_interrupt)) && !fault |=> $stable(latch_q))
    else $error("push or pop changed the latch");
  overflow_flag_a: assert property (
    ovf_evt |=> st_q[pc_stack_pkg::ST_OVF] ##1 irq_o == msk_q[0])
    else $error("overflow flag not set");
  fault_reset_a: assert property (
    fault |=> fault_reset_o && pc_q == 15'h0000 && sp_q == 5'h1f)
    else $error("stack fault did not reset");
  return_from_interrupt_restore_a: assert property (
    is_return_from_interrupt && !fault |=> ctx_restore_o && latch_q == $past(latch_sh_q))
    else $error("return from interrupt did not restore");

  // further targets and stack moves; expressions restated from the rules
  // rather than from the muxes above, so a wrong select still shows; pop_read_a alone reuses tos
  computed_call_target_a: assert property (
    cmd_i == pc_stack_pkg::CMD_COMPUTED_CALL && !fault |=>
      pc_q == {$past(latch_q), $past(data_i)})
    else $error("computed call target wrong");
  pcl_bus_a: assert property (
    bus_wr && hit_pcl && cmd_i == pc_stack_pkg::CMD_NONE |=>
      pc_q == {$past(latch_q), $past(wd)})
    else $error("bus low byte write did not load latch");
  pop_read_a: assert property (
    is_pop && !fault |=> pc_q == $past(tos)
      && sp_q == 5'($past(sp_q) - 5'h01))
    else $error("pop did not read then decrement");
  wrap_store_a: assert property (
    ovf_evt && !fault_en_q |=> sp_q == 5'h10
      && stack_q[4'h0] == $past(pc_q))
    else $error("wrapping push did not overwrite oldest entry");
  underflow_flag_a: assert property (
    unf_evt |=> st_q[pc_stack_pkg::ST_UNF])
    else $error("underflow flag not set");
  flag_clear_a: assert property (
    bus_wr && hit_st && wd[0] && !ovf_evt |=> !st_q[pc_stack_pkg::ST_OVF])
    else $error("overflow flag did not clear");
  fault_latch_a: assert property (
    fault |=> latch_q == 7'h00 && !ctx_restore_o)
    else $error("stack fault did not clear the latch");
  irq_ctx_a: assert property (
    is_irq && !fault |=> working_reg_shadow_o == $past(data_i)
      && fsr0_shadow_o == $past(fsr0_i) && fsr1_shadow_o == $past(fsr1_i))
    else $error("interrupt entry did not save context");
  reset_quiet_a: assert property (
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> !ack_o && !irq_o && !fault_reset_o && !ctx_restore_o)
    else $error("reset left an output active");

  // level is registered from the next flags, so it moves with them and follows the mask one cycle late
  irq_level_a: assert property (
    1'b1 |=> irq_o == |(st_q & $past(msk_q)))
    else $error("interrupt level does not follow flags");
  // bus answer never stretches into a second cycle
  ack_pulse_a: assert property (
    ack_o |=> !ack_o)
    else $error("acknowledge held for two cycles");

  call_cov_c: cover property (cmd_i == pc_stack_pkg::CMD_CALL ##1
    cmd_i == pc_stack_pkg::CMD_NONE ##1 cmd_i == pc_stack_pkg::CMD_RETURN);
  tos_cov_c: cover property (bus_req && hit_top_of_stack_high ##1 ack_o);
  wrap_cov_c: cover property (ovf_evt && !fault_en_q);
  fault_cov_c: cover property (fault ##1 fault_reset_o);
  irq_cov_c: cover property (is_irq ##[1:20] is_return_from_interrupt);
endmodule : pc_stack

// ==== verification/decoder_model.sv ====
// decoder and interrupt logic model driving the sequencer's command port
// assumes a single core clock; commands are one per call, then idle
`timescale 1ns/100ps
module decoder_model (
  input wire logic clk_i, // core clock
  output logic [3:0] cmd_o, // command to the sequencer
  output logic [10:0] operand_o, // instruction operand
  output logic [7:0] data_o, // working reg or alu result
  output logic [2:0] status_o, // flags offered for saving
  output logic [4:0] bsr_o, // bank select offered
  output logic [15:0] fsr0_o, // pointer 0 offered
  output logic [15:0] fsr1_o // pointer 1 offered
);
  // idle from time zero so reset sees no command
  initial begin
    cmd_o = pc_stack_pkg::CMD_NONE;
    operand_o = 11'h000;
    data_o = 8'h00;
    {status_o, bsr_o, fsr0_o, fsr1_o} = 40'h0;
  end

  // one command for one cycle; operand and data show junk when idle so
  // a sequencer that samples them late cannot get the right value by luck
  task automatic issue(input logic [3:0] c, input logic [10:0] o,
                       input logic [7:0] d, input logic [39:0] ctx);
    @(posedge clk_i);
    cmd_o <= c;
    operand_o <= o;
    data_o <= d;
    {status_o, bsr_o, fsr0_o, fsr1_o} <= ctx;
    @(posedge clk_i);
    cmd_o <= pc_stack_pkg::CMD_NONE;
    operand_o <= ~o;
    data_o <= ~d;
    #1;
  endtask : issue
endmodule : decoder_model

// ==== verification/pc_stack_test.sv ====
// self-checking bench for the program counter and return stack
// assumes decoder_model as command source and a wishbone host task here
`timescale 1ns/100ps
module pc_stack_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o, rd;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic ack_o, ctx_restore_o, fault_reset_o, irq_o;
  logic [14:0] pc_o;
  logic [6:0] pc_high_latch_o;
  logic [2:0] status_shadow_o, st_w;
  logic [7:0] working_reg_shadow_o, dw;
  logic [4:0] bank_select_shadow_o, bsr_w;
  logic [15:0] fsr0_shadow_o, fsr1_shadow_o, f0_w, f1_w;
  logic [3:0] cmd;
  logic [10:0] op_w;
  integer seed = 32'h4c03;
  integer miscompares = 0;
  integer num_checks = 0;
  // reference state of counter, latch and stack
  logic [14:0] m_pc, stk [16];
  logic [6:0] m_lat, sh_lat;
  logic [4:0] m_sp = 5'h1f;
  logic [1:0] m_msk = 2'b00;
  logic ovf = 1'b0, unf = 1'b0, fen = 1'b1, flt;
  logic [3:0] mix [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha,
                          4'hb};

  always #20 clk_i = ~clk_i;

  pc_stack uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
    .sel_i(4'h1), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o),
    .ack_o(ack_o), .cmd_i(cmd), .operand_i(op_w), .data_i(dw),
    .status_i(st_w), .bsr_i(bsr_w), .fsr0_i(f0_w), .fsr1_i(f1_w),
    .pc_o(pc_o), .pc_high_latch_o(pc_high_latch_o),
    .ctx_restore_o(ctx_restore_o), .status_shadow_o(status_shadow_o),
    .working_reg_shadow_o(working_reg_shadow_o),
    .bank_select_shadow_o(bank_select_shadow_o),
    .fsr0_shadow_o(fsr0_shadow_o), .fsr1_shadow_o(fsr1_shadow_o),
    .fault_reset_o(fault_reset_o), .irq_o(irq_o));

  decoder_model dec (.clk_i(clk_i), .cmd_o(cmd), .operand_o(op_w),
    .data_o(dw), .status_o(st_w), .bsr_o(bsr_w), .fsr0_o(f0_w),
    .fsr1_o(f1_w));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // classic cycle; ack is sampled before the edge's own updates land
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 8'h00);
    check(rd, exp);
  endtask : rdchk

  // interrupt level moves with any flag change and follows a mask change one cycle late
  task automatic irqchk;
    @(posedge clk_i);
    #1;
    check(irq_o, |({unf, ovf} & m_msk));
  endtask : irqchk

  function automatic logic [14:0] next_pc(input logic [3:0] c,
      input logic [10:0] o, input logic [7:0] d);
    case (c)
      pc_stack_pkg::CMD_STEP: return m_pc + 15'h1;
      pc_stack_pkg::CMD_CALL: return {m_lat[6:3], o};
      pc_stack_pkg::CMD_COMPUTED_CALL, pc_stack_pkg::CMD_WR_PCL: return {m_lat, d};
      pc_stack_pkg::CMD_BRW: return m_pc + 15'h1 + {7'h0, d};
      pc_stack_pkg::CMD_BRA: return m_pc + 15'h1 + {{6{o[8]}}, o[8:0]};
      pc_stack_pkg::CMD_IRQ: return pc_stack_pkg::IRQ_VECTOR;
      default: return m_pc;
    endcase
  endfunction : next_pc

  // issue one command, update the reference and compare counter, latch, fault, restore and shadow outputs
  task automatic do_cmd(input logic [3:0] c, input logic [10:0] o,
                        input logic [7:0] d);
    logic push, pop;
    logic [14:0] e;
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    push = c inside {4'h2, 4'h3, 4'h9};
    pop = c inside {4'h6, 4'h7, 4'h8};
    e = next_pc(c, o, d);
    flt = fen && ((push && m_sp == 5'h0f) || (pop && m_sp == 5'h1f));
    ovf = ovf | (push && m_sp == 5'h0f);
    unf = unf | (pop && m_sp == 5'h1f);
    if (flt) begin
      e = 15'h0;
      m_sp = 5'h1f;
      m_lat = 7'h00;
    end else if (push) begin
      m_sp = m_sp + 5'h01;
      stk[m_sp[3:0]] = m_pc;
    end else if (pop) begin
      e = stk[m_sp[3:0]];
      m_sp = m_sp - 5'h01;
    end
    if (c == pc_stack_pkg::CMD_IRQ && !flt) sh_lat = m_lat;
    if (c == pc_stack_pkg::CMD_RETURN_FROM_INTERRUPT && !flt) m_lat = sh_lat;
    if (c == pc_stack_pkg::CMD_WR_LATCH) m_lat = d[6:0];
    dec.issue(c, o, d, r[39:0]);
    check(pc_o, e);
    check(pc_high_latch_o, m_lat);
    check(fault_reset_o, flt);
    check(ctx_restore_o, c == pc_stack_pkg::CMD_RETURN_FROM_INTERRUPT && !flt);
    if (c == pc_stack_pkg::CMD_IRQ && !flt) begin
      check({fsr0_shadow_o, fsr1_shadow_o}, {f0_w, f1_w});
      check({status_shadow_o, bank_select_shadow_o, working_reg_shadow_o},
            {st_w, bsr_w, d});
    end
    m_pc = e;
  endtask : do_cmd

  // reset, directed corners, random mix, then stack wrap and faults
  initial begin
    integer i;
    logic [31:0] r;
    logic [3:0] c;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check(pc_o, pc_stack_pkg::PC_RST);
    rdchk(pc_stack_pkg::IDX_SP, pc_stack_pkg::SP_EMPTY);
    rdchk(12'h3ff, 32'h0);
    r = $random(seed);
    wb(1'b1, pc_stack_pkg::IDX_LATCH, r[7:0]);
    wb(1'b1, pc_stack_pkg::IDX_PCL, r[15:8]);
    m_lat = r[6:0];
    m_pc = {m_lat, r[15:8]};
    check(pc_o, m_pc);
    rdchk(pc_stack_pkg::IDX_PCL, m_pc[7:0]);
    do_cmd(pc_stack_pkg::CMD_CALL, r[26:16], 8'h00);
    rdchk(pc_stack_pkg::IDX_TOP_OF_STACK_LOW, stk[0][7:0]);
    rdchk(pc_stack_pkg::IDX_TOP_OF_STACK_HIGH, stk[0][14:8]);
    rdchk(pc_stack_pkg::IDX_SP, 32'h0);
    do_cmd(pc_stack_pkg::CMD_WR_PCL, 11'h0, m_pc[7:0] + 8'hf0);
    do_cmd(pc_stack_pkg::CMD_BRW, 11'h0, 8'hff);
    do_cmd(pc_stack_pkg::CMD_BRA, 11'h100, 8'h00);
    do_cmd(pc_stack_pkg::CMD_IRQ, 11'h0, r[23:16]);
    do_cmd(pc_stack_pkg::CMD_WR_LATCH, 11'h0, ~r[7:0]);
    do_cmd(pc_stack_pkg::CMD_RETURN_FROM_INTERRUPT, 11'h0, 8'h00);
    // random mix; never faults while the option is on
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      c = mix[r[31:28] % 9];
      if (m_sp == 5'h1f) c = pc_stack_pkg::CMD_CALL;
      if (m_sp == 5'h0f) c = pc_stack_pkg::CMD_STEP;
      do_cmd(c, r[26:16], r[7:0]);
    end
    // option off: push past sixteen wraps onto the oldest entry
    wb(1'b1, pc_stack_pkg::IDX_CTRL, 8'h00);
    fen = 1'b0;
    for (i = 0; i < 18 && m_sp != 5'h10; i++)
      do_cmd(pc_stack_pkg::CMD_CALL, 11'(i * 37), 8'h00);
    rdchk(pc_stack_pkg::IDX_IRQ_ST, {unf, ovf});
    irqchk();
    wb(1'b1, pc_stack_pkg::IDX_IRQ_MSK, 8'h03);
    m_msk = 2'b11;
    irqchk();
    wb(1'b1, pc_stack_pkg::IDX_IRQ_ST, 8'h01);
    ovf = 1'b0;
    irqchk();
    for (i = 0; i < 18 && m_sp != 5'h1f; i++)
      do_cmd(pc_stack_pkg::CMD_RETURN, 11'h0, 8'h00);
    // option on: underflow and then overflow reset the sequencer
    wb(1'b1, pc_stack_pkg::IDX_CTRL, 8'h01);
    fen = 1'b1;
    do_cmd(pc_stack_pkg::CMD_RETURN_WITH_LITERAL, 11'h0, 8'h00);
    irqchk();
    rdchk(pc_stack_pkg::IDX_IRQ_ST, {unf, ovf});
    wb(1'b1, pc_stack_pkg::IDX_IRQ_ST, 8'h03);
    unf = 1'b0;
    irqchk();
    for (i = 0; i < 17; i++)
      do_cmd(pc_stack_pkg::CMD_CALL, 11'(i * 91), 8'h00);
    rdchk(pc_stack_pkg::IDX_SP, pc_stack_pkg::SP_EMPTY);
    finish_test();
  end
endmodule : pc_stack_test
